/* core/gpio_output_config_bank.sv */
// Output-side configuration of fifteen general purpose pins, AXI4-Lite slave.
// Assumes pads resolve pin level from out/oe_n; secondary function drives its own pins.
// Functional notes
// - Fifteen configurable pins, two banks
// - Pins 0-8 low bank, 9-14 high
// - Each pin push-pull, open-drain, or input
// - Reset state: pins 6-14 CMOS input, weak pull-down
// - Byte layout: alt, dir, drv, pull
// - Pins 0-5 reset 0x7C, others 0x0C
// - Direction 1 output; driver 1 push-pull
// - Pull enable bit connects the resistor
// - Pull codes: 00 2k down, 10/11 50k
// - Level 0 drives low; 1 high/release
module gpio_output_config_bank
  import gpio_cfg_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PINS-1:0] alt_out,
  input wire logic [PINS-1:0] alt_oe_n,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  output logic [PINS-1:0] pin_in_sync,
  output pull_ctrl_type [PINS-1:0] pin_pull,
  output logic [PINS-1:0] pin_high_bank
);
  // Register map, byte address is four times the word index:
  //   pin0_output_config  index 0x3b, byte 0x0ec
  //   pin1_output_config  index 0x3c, byte 0x0f0
  //   pin2_output_config  index 0x3d, byte 0x0f4
  //   pin3_output_config  index 0x3e, byte 0x0f8
  //   pin4_output_config  index 0x3f, byte 0x0fc
  //   pin5_output_config  index 0x40, byte 0x100
  //   pin6_output_config  index 0x41, byte 0x104
  //   pin7_output_config  index 0x42, byte 0x108
  //   pin8_output_config  index 0x2b, byte 0x0ac
  //   pin9_output_config  index 0x2c, byte 0x0b0
  //   pin10_output_config index 0x2d, byte 0x0b4
  //   pin11_output_config index 0x2e, byte 0x0b8
  //   pin12_output_config index 0x2f, byte 0x0bc
  //   pin13_output_config index 0x30, byte 0x0c0
  //   pin14_output_config index 0x31, byte 0x0c4
  // Any other word, or a misaligned byte address, answers with an error
  // and changes nothing; reads of such addresses return zero.

  // Elaboration checks: the decode and the reset groups assume these sizes
  initial begin
    if (PINS != PIN_COUNT) begin
      $error("gpio bank supports exactly fifteen pins");
    end
    if (CFG_WIDTH != 8) begin
      $error("configuration registers must be eight bits wide");
    end
    if (ADDR_WIDTH != 12) begin
      $error("address decode expects a twelve bit byte address");
    end
    if (LOW_BANK_PINS >= PINS || HIGH_GROUP_PINS >= PINS) begin
      $error("bank or reset group split outside the pin range");
    end
  end

  // Reset release through two flops; assert stays asynchronous
  // Release is synchronous so no register leaves reset a cycle apart
  // from its neighbours; the bus must wait two edges after release.
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Pin input synchroniser; stage one feeds only stage two
  // Pads change with no relation to clk, so nothing else may read the
  // first stage; software sees a level two cycles late at worst.
  logic [PINS-1:0] in_meta_q;
  logic [PINS-1:0] in_sync_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= '0;
      in_sync_q <= '0;
    end else begin
      in_meta_q <= pin_in;
      in_sync_q <= in_meta_q;
    end
  end
  assign pin_in_sync = in_sync_q;

  // Write channel: address and data latched in either order
  // Each half is held until its partner arrives; the register is updated
  // on the edge that takes the last half, and bvalid rises with it.
  // Both readies stay low while a response waits, which keeps at most
  // one write in flight and needs no queue of responses.
  logic aw_held_q, aw_held_d;
  logic w_held_q, w_held_d;
  logic [ADDR_WIDTH-1:0] waddr_q, waddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic do_write;
  logic wr_hit;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic rd_hit;

  // Address decode against the printed indexes
  function automatic logic [4:0] decode(input logic [ADDR_WIDTH-1:0] addr);
    logic [4:0] res;
    res = 5'h1f;
    if (addr[1:0] == 2'h0) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (addr[ADDR_WIDTH-1:2] == {2'h0, REG_INDEX[i]}) res = 5'(i);
      end
    end
    return res;
  endfunction

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;

  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d = w_held_q;
    waddr_d = waddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      waddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    // Both halves present and no answer pending; computed here so the
    // held flags do not loop back through a separate assignment
    do_write = aw_held_d && w_held_d && !bvalid_q;
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (decode(waddr_d) == 5'h1f) ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      waddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      waddr_q <= waddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write target; only byte lane 0 carries the 8-bit register
  // A write with lane 0 masked still answers OKAY but leaves the byte
  always_comb begin
    logic [4:0] hit;
    hit = decode(waddr_d);
    wr_hit = do_write && (hit != 5'h1f) && wlane_d;
    wr_idx = hit[3:0];
  end

  // Per-pin configuration registers and pad control
  // Pad controls are decoded straight from the stored byte, so a new
  // setting reaches the pins in the cycle after the write edge.
  // Bit 7 is never stored as one: writes pass through the mask.
  pin_output_config_type cfg_q [PINS];
  pin_output_config_type cfg_d [PINS];
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    localparam logic [7:0] RST_VAL = (p < HIGH_GROUP_PINS) ? RESET_HIGH_GROUP : RESET_LOW_GROUP;
    always_comb begin
      cfg_d[p] = cfg_q[p];
      if (wr_hit && wr_idx == 4'(p)) cfg_d[p] = pin_output_config_type'(wbyte_d & WRITE_MASK);
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cfg_q[p] <= pin_output_config_type'(RST_VAL);
      else cfg_q[p] <= cfg_d[p];
    end
    // Output stage: push-pull drives both levels, open-drain only low
    always_comb begin
      if (cfg_q[p].secondary_role_enable) begin
        pin_out[p] = alt_out[p];
        pin_oe_n[p] = alt_oe_n[p];
      end else if (!cfg_q[p].direction) begin
        pin_out[p] = 1'b0;
        pin_oe_n[p] = 1'b1;
      end else if (cfg_q[p].driver_style) begin
        pin_out[p] = cfg_q[p].level;
        pin_oe_n[p] = 1'b0;
      end else begin
        pin_out[p] = 1'b0;
        pin_oe_n[p] = cfg_q[p].level;
      end
    end
    // Undefined pull code 01 connects nothing, the safe choice
    always_comb begin
      pin_pull[p] = '0;
      if (cfg_q[p].pull_enable) begin
        unique case (cfg_q[p].pull_strength_select)
          PULL_DOWN_STRONG: pin_pull[p].pull_down_strong = 1'b1;
          PULL_DOWN_WEAK: pin_pull[p].pull_down_weak = 1'b1;
          PULL_UP_WEAK: pin_pull[p].pull_up_weak = 1'b1;
          PULL_UNDEFINED: pin_pull[p] = '0;
        endcase
      end
    end
    assign pin_high_bank[p] = (p >= LOW_BANK_PINS);
  end

  // Read channel: one-cycle answer, held until rready
  // The address is decoded in the cycle it is offered; rdata is a
  // register so it stays stable however long the master stalls.
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  assign s_axi_arready = !rvalid_q;
  always_comb begin
    logic [4:0] hit;
    hit = decode(s_axi_araddr);
    rd_hit = hit != 5'h1f;
    rd_idx = hit[3:0];
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d = rd_hit ? {24'h000000, 8'(cfg_q[rd_idx])} : 32'h00000000;
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
endmodule

/* inc/gpio_cfg_pkg.sv */
// Package for the general purpose pin output configuration bank.
// Assumes a single 20 MHz system clock and an AXI4-Lite register master.
package gpio_cfg_pkg;
  localparam int PIN_COUNT = 15;
  localparam int LOW_BANK_PINS = 9;
  localparam int CFG_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;
  // Printed offsets are register indexes; byte address is four times each
  localparam logic [7:0] REG_INDEX [PIN_COUNT] = '{
    8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h42,
    8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31};
  localparam logic [7:0] RESET_HIGH_GROUP = 8'h7c;
  localparam logic [7:0] RESET_LOW_GROUP = 8'h0c;
  localparam int HIGH_GROUP_PINS = 6;
  // Field positions in each configuration byte
  localparam int BIT_SECONDARY = 6;
  localparam int BIT_DIRECTION = 5;
  localparam int BIT_DRIVER = 4;
  localparam int BIT_PULL_EN = 3;
  localparam int BIT_PULL_HI = 2;
  localparam int BIT_PULL_LO = 1;
  localparam int BIT_LEVEL = 0;
  localparam logic [7:0] WRITE_MASK = 8'h7f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PULL_DOWN_STRONG = 2'h0,
    PULL_UNDEFINED = 2'h1,
    PULL_DOWN_WEAK = 2'h2,
    PULL_UP_WEAK = 2'h3
  } pull_code_type;
  typedef struct packed {
    logic reserved;
    logic secondary_role_enable;
    logic direction;
    logic driver_style;
    logic pull_enable;
    pull_code_type pull_strength_select;
    logic level;
  } pin_output_config_type;
  // Pad control bundle per pin
  typedef struct packed {
    logic pull_up_weak;
    logic pull_down_weak;
    logic pull_down_strong;
  } pull_ctrl_type;
endpackage

/* verification/gpio_output_config_properties.sv */
// Port properties of the pin output configuration bank.
// Bound into the bank; one clock, reset_n low resets.
module gpio_output_config_properties
  import gpio_cfg_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk, reset_n, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [PINS-1:0] pin_oe_n, pin_high_bank,
  input wire pull_ctrl_type [PINS-1:0] pin_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Bus side: answers held until the master takes them
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == '0)
    else $error("reserved bits set");
  // Pin side: bank split, reset state, pulls never fight
  a_bank_split: assert property (pin_high_bank == 15'h7e00)
    else $error("bank split wrong");
  a_reset_input: assert property ($rose(reset_n) |-> &pin_oe_n[14:6] && pin_pull[14] == 3'h2)
    else $error("reset pin state wrong");
  a_pull_single: assert property ($onehot0(pin_pull[0]) && $onehot0(pin_pull[10]))
    else $error("two pulls at once");
endmodule

bind gpio_output_config_bank gpio_output_config_properties #(.PINS(PINS)) gpio_output_config_properties_i (
  .clk, .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_rdata, .pin_oe_n, .pin_high_bank,
  .pin_pull);

/* verification/gpio_pad_model.sv */
// Board side of the fifteen pins: drivers, pulls, floating lines.
// Assumes oe_n low means the bank drives the pin.
module gpio_pad_model
  import gpio_cfg_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk,
  input wire logic [PINS-1:0] pin_out, pin_oe_n,
  input wire pull_ctrl_type [PINS-1:0] pin_pull,
  output logic [PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PINS-1:0] float_q = '0;
  // Floating level toggles so a stale value is never trusted
  always @(posedge clk) float_q <= ~float_q;
  // Driver wins, then pull-up, then either pull-down
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      pin_in[i] = float_q[i];
      if (pin_pull[i].pull_down_weak || pin_pull[i].pull_down_strong) pin_in[i] = 1'b0;
      if (pin_pull[i].pull_up_weak) pin_in[i] = 1'b1;
      if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
    end
  end
endmodule

/* verification/tb_top.sv */
// Bench: AXI4-Lite sequences on the pin configuration bank.
// Pad model closes the pin loop; the checker is bound.
module tb_top;
  import gpio_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [14:0] alt_out = '0, alt_oe_n = '1, pin_in, pin_out, pin_oe_n, pin_in_sync, pin_high_bank;
  pull_ctrl_type [14:0] pin_pull;
  logic [7:0] role[5] = '{8'h31, 8'h30, 8'h2f, 8'h20, 8'h0f};
  logic [2:0] pull_exp[5] = '{3'h1, 3'h0, 3'h2, 3'h4, 3'h0};
  int err_total = 0, n_compared = 0;
  // Twenty megahertz clock
  initial forever #25 clk = ~clk;
  gpio_output_config_bank gpio_output_config_bank_i (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .alt_out, .alt_oe_n, .pin_in, .pin_out, .pin_oe_n, .pin_in_sync, .pin_pull, .pin_high_bank);
  gpio_pad_model gpio_pad_model_i (.clk, .pin_out, .pin_oe_n, .pin_pull, .pin_in);
  // Printed offsets are word indexes
  function automatic logic [11:0] ad(input int p);
    return {2'b00, REG_INDEX[p], 2'b00};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Ready is sampled mid-cycle, so release never races the edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw, da = 0, dw = 0;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, 24'h0, d, 2'b11};
    while (!(da && dw)) begin
      @(negedge clk);
      {ta, tw} = {s_axi_awvalid && s_axi_awready, s_axi_wvalid && s_axi_wready};
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      {da, dw} = {da | ta, dw | tw};
    end
    do @(negedge clk); while (!s_axi_bvalid);
    chk("bresp", 32'(r), 32'(s_axi_bresp));
    @(posedge clk) s_axi_bready <= 1'b1;
    @(posedge clk) s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk) s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    chk("rdata", {24'h0, d}, s_axi_rdata);
    chk("rresp", 32'(r), 32'(s_axi_rresp));
    @(posedge clk) s_axi_rready <= 1'b1;
    @(posedge clk) s_axi_rready <= 1'b0;
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("bank", 32'h7e00, 32'(pin_high_bank));
    chk("pull14", 32'h2, 32'(pin_pull[14]));
    for (int p = 0; p < 15; p++) rd(ad(p), p < 6 ? 8'h7c : 8'h0c, RESP_OKAY);
    $display("test reset done");
    wr(ad(8), 8'hff, RESP_OKAY);
    rd(ad(8), 8'h7f, RESP_OKAY);
    wr(12'h000, 8'h5a, RESP_SLVERR);
    rd(12'h000, 8'h00, RESP_SLVERR);
    s_axi_wstrb <= 4'he;
    wr(ad(8), 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ad(8), 8'h7f, RESP_OKAY);
    $display("test layout done");
    // Every role on one pin of each bank; released pins have a pull-up
    for (int k = 2; k < 16; k += 7) for (int j = 0; j < 5; j++) begin
      wr(ad(k), role[j], RESP_OKAY);
      repeat (3) @(negedge clk);
      chk("oe_n", 32'(!role[j][5] || !role[j][4] && role[j][0]), 32'(pin_oe_n[k]));
      chk("level", 32'(role[j][0]), 32'(pin_in_sync[k]));
    end
    for (int c = 0; c < 5; c++) begin
      wr(ad(10), c < 4 ? 8'(8 + 2 * c) : 8'h06, RESP_OKAY);
      @(negedge clk);
      chk("pull", 32'(pull_exp[c]), 32'(pin_pull[10]));
    end
    wr(ad(11), 8'h40, RESP_OKAY);
    {alt_out[11], alt_oe_n[11]} <= 2'b10;
    @(negedge clk);
    chk("alt", 32'h2, 32'({pin_out[11], pin_oe_n[11]}));
    wr(ad(11), 8'h00, RESP_OKAY);
    @(negedge clk);
    chk("plain", 32'h1, 32'({pin_out[11], pin_oe_n[11]}));
    $display("test roles done");
    conclude();
  end
  // About 200 cycles of traffic expected
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
